//--- shared/ssd_pkg.sv
package ssd_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int OUT_W = 16;
    localparam int DIG_W = 4;
    localparam int SEG_W = 7;
    localparam int MODE_W = 3;
    localparam int STEP_W = 4;
    localparam int ROUND_W = 8;

    // register offsets on the plain register port
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SRC = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_OUT = 8'h0C;

    // control register layout: mode code in the low bits, run above it
    localparam int CTRL_RUN_BIT = 3;
    localparam int MODE_LATCH_INV = 0;
    localparam int MODE_DATA_INV = 1;
    localparam int MODE_EIGHT = 2;

    // status register layout
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_STEP_POS = 4;
    localparam int STAT_ROUND_POS = 8;

    // output readback layout
    localparam int RB_SEG_L_POS = 16;
    localparam int RB_SEG_R_POS = 23;

    // reset values
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [31:0] SRC_RST = 32'h0000_0000;
    localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;
    localparam logic [7:0] ROUND_RST = 8'h00;

    // one round is twelve scan steps, three per digit slot
    localparam logic [3:0] STEP_FIRST = 4'h0;
    localparam logic [3:0] STEP_LAST = 4'hB;
    localparam logic [3:0] STEPS_PER_DIGIT = 4'h3;
    localparam logic [1:0] PHASE_SETUP = 2'h0;
    localparam logic [1:0] PHASE_STROBE = 2'h1;
    localparam logic [1:0] PHASE_HOLD = 2'h2;

    // output word bit positions, 4-digit mode
    localparam int POS4_DATA = 0;
    localparam int POS4_STRB = 4;
    localparam int POS4_FLAG = 8;

    // output word bit positions, 8-digit mode
    localparam int POS8_LDATA = 0;
    localparam int POS8_RDATA = 4;
    localparam int POS8_STRB = 8;
    localparam int POS8_FLAG = 12;

    typedef enum logic [0:0] {
        SSD_IDLE = 1'b0,
        SSD_RUN = 1'b1
    } ssd_state_type;
endpackage

//--- shared/ssd_dig_if.sv
`timescale 1ns/1ps
interface ssd_dig_if;
    logic [3:0] bcd_left;
    logic [3:0] bcd_right;
    logic [6:0] seg_left;
    logic [6:0] seg_right;

    modport drv (
        output bcd_left,
        output bcd_right,
        input seg_left,
        input seg_right
    );
    modport dec (
        input bcd_left,
        input bcd_right,
        output seg_left,
        output seg_right
    );
endinterface

//--- verilog/ssd_seg_decoder.sv
`timescale 1ns/1ps
module ssd_seg_decoder (
    ssd_dig_if.dec dig // digit codes in, segment patterns out
);
    // segment order gfedcba; codes above nine blank the digit
    function automatic logic [6:0] bcd_to_seg(input logic [3:0] d);
        logic [6:0] s;
        s = 7'h00;
        case (d)
            4'h0: s = 7'h3F;
            4'h1: s = 7'h06;
            4'h2: s = 7'h5B;
            4'h3: s = 7'h4F;
            4'h4: s = 7'h66;
            4'h5: s = 7'h6D;
            4'h6: s = 7'h7D;
            4'h7: s = 7'h07;
            4'h8: s = 7'h7F;
            4'h9: s = 7'h6F;
            default: s = 7'h00;
        endcase
        return s;
    endfunction

    assign dig.seg_left = bcd_to_seg(dig.bcd_left);
    assign dig.seg_right = bcd_to_seg(dig.bcd_right);
endmodule

//--- verilog/ssd_mux_driver.sv
`timescale 1ns/1ps
module ssd_mux_driver (
    input wire logic i_clk, // scan clock, one step per edge
    input wire logic i_nrst, // synchronous reset, active low
    input wire logic [7:0] i_addr, // register byte address
    input wire logic [31:0] i_wdata, // register write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [31:0] o_rdata, // read data, cycle after i_rd
    output logic [15:0] o_out_word, // data, strobes and round flag
    output logic [6:0] o_seg_left, // left group segment pattern
    output logic [6:0] o_seg_right, // right group segment pattern
    output logic o_running // scanning is active
);
    ssd_pkg::ssd_state_type state_reg;
    ssd_pkg::ssd_state_type state_next;
    logic [3:0] step_reg;
    logic [31:0] snap_reg;
    logic [2:0] mode_reg;
    logic [2:0] ctrl_mode_reg;
    logic ctrl_run_reg;
    logic [31:0] src_reg;
    logic [7:0] round_reg;
    logic [15:0] out_reg;
    logic [15:0] out_next;
    logic [6:0] seg_left_reg;
    logic [6:0] seg_right_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic run_now;
    logic round_start;
    logic [2:0] cur_mode;
    logic eight;
    logic data_inv;
    logic latch_inv;
    logic [1:0] dig_idx;
    logic [1:0] phase;
    logic [3:0] left_raw;
    logic [3:0] right_raw;
    logic [3:0] left_lvl;
    logic [3:0] right_lvl;
    logic [3:0] strobe_raw;
    logic [3:0] strobe_lvl;
    logic flag_comb;

    ssd_dig_if dig();

    ssd_seg_decoder u_dec (
        .dig(dig.dec)
    );

    function automatic logic [1:0] step_digit(input logic [3:0] s);
        return 2'(s / ssd_pkg::STEPS_PER_DIGIT);
    endfunction

    function automatic logic [1:0] step_phase(input logic [3:0] s);
        return 2'(s % ssd_pkg::STEPS_PER_DIGIT);
    endfunction

    function automatic logic [3:0] pick(input logic [31:0] w,
                                        input logic [2:0] i);
        return w[{i, 2'b00} +: 4];
    endfunction

    assign run_now = (state_reg == ssd_pkg::SSD_RUN);
    // mode steering comes from the round's snapshot while running
    assign cur_mode = run_now ? mode_reg : ctrl_mode_reg;
    assign eight = cur_mode[ssd_pkg::MODE_EIGHT];
    assign data_inv = cur_mode[ssd_pkg::MODE_DATA_INV];
    assign latch_inv = cur_mode[ssd_pkg::MODE_LATCH_INV];
    assign dig_idx = step_digit(step_reg);
    assign phase = step_phase(step_reg);
    // restart or wrap both reload the round's inputs
    assign round_start = ctrl_run_reg &&
        (!run_now || step_reg == ssd_pkg::STEP_LAST);

    // register writes
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ctrl_mode_reg <= ssd_pkg::MODE_RST;
            ctrl_run_reg <= 1'b0;
        end else if (i_wr && i_addr == ssd_pkg::REG_CTRL) begin
            ctrl_mode_reg <= i_wdata[ssd_pkg::MODE_W-1:0];
            ctrl_run_reg <= i_wdata[ssd_pkg::CTRL_RUN_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            src_reg <= ssd_pkg::SRC_RST;
        end else if (i_wr && i_addr == ssd_pkg::REG_SRC) begin
            src_reg <= i_wdata;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ssd_pkg::SSD_IDLE: begin
                if (ctrl_run_reg) begin
                    state_next = ssd_pkg::SSD_RUN;
                end
            end
            ssd_pkg::SSD_RUN: begin
                if (!ctrl_run_reg) begin
                    state_next = ssd_pkg::SSD_IDLE;
                end
            end
            default: state_next = ssd_pkg::SSD_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state_reg <= ssd_pkg::SSD_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            step_reg <= ssd_pkg::STEP_FIRST;
        end else if (round_start || !ctrl_run_reg) begin
            step_reg <= ssd_pkg::STEP_FIRST;
        end else begin
            step_reg <= 4'(step_reg + 4'h1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            snap_reg <= ssd_pkg::SRC_RST;
            mode_reg <= ssd_pkg::MODE_RST;
        end else if (round_start) begin
            snap_reg <= src_reg;
            mode_reg <= ctrl_mode_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            round_reg <= ssd_pkg::ROUND_RST;
        end else if (run_now && ctrl_run_reg &&
                     step_reg == ssd_pkg::STEP_LAST) begin
            round_reg <= 8'(round_reg + 8'h01);
        end
    end

    assign left_raw = pick(snap_reg, {eight, dig_idx});
    assign right_raw = pick(snap_reg, {1'b0, dig_idx});
    assign dig.bcd_left = left_raw;
    assign dig.bcd_right = right_raw;

    assign strobe_raw = (run_now && phase == ssd_pkg::PHASE_STROBE) ?
        4'(4'h1 << dig_idx) : 4'h0;
    assign strobe_lvl = strobe_raw ^ {4{latch_inv}};
    assign left_lvl = run_now ? (left_raw ^ {4{data_inv}}) : 4'h0;
    assign right_lvl = (run_now && eight) ?
        (right_raw ^ {4{data_inv}}) : 4'h0;
    assign flag_comb = run_now && step_reg == ssd_pkg::STEP_LAST;

    always_comb begin
        out_next = '0;
        if (eight) begin
            out_next[ssd_pkg::POS8_LDATA +: 4] = left_lvl;
            out_next[ssd_pkg::POS8_RDATA +: 4] = right_lvl;
            out_next[ssd_pkg::POS8_STRB +: 4] = strobe_lvl;
            out_next[ssd_pkg::POS8_FLAG] = flag_comb;
        end else begin
            out_next[ssd_pkg::POS4_DATA +: 4] = left_lvl;
            out_next[ssd_pkg::POS4_STRB +: 4] = strobe_lvl;
            out_next[ssd_pkg::POS4_FLAG] = flag_comb;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            out_reg <= '0;
            seg_left_reg <= '0;
            seg_right_reg <= '0;
        end else begin
            out_reg <= out_next;
            seg_left_reg <= run_now ?
                (dig.seg_left ^ {7{data_inv}}) : 7'h00;
            seg_right_reg <= (run_now && eight) ?
                (dig.seg_right ^ {7{data_inv}}) : 7'h00;
        end
    end

    always_comb begin
        rdata_next = ssd_pkg::RDATA_IDLE;
        case (i_addr)
            ssd_pkg::REG_CTRL: begin
                rdata_next[ssd_pkg::MODE_W-1:0] = ctrl_mode_reg;
                rdata_next[ssd_pkg::CTRL_RUN_BIT] = ctrl_run_reg;
            end
            ssd_pkg::REG_SRC: rdata_next = src_reg;
            ssd_pkg::REG_STATUS: begin
                rdata_next[ssd_pkg::STAT_RUN_BIT] = run_now;
                rdata_next[ssd_pkg::STAT_STEP_POS +: 4] = step_reg;
                rdata_next[ssd_pkg::STAT_ROUND_POS +: 8] = round_reg;
            end
            ssd_pkg::REG_OUT: begin
                rdata_next[ssd_pkg::OUT_W-1:0] = out_reg;
                rdata_next[ssd_pkg::RB_SEG_L_POS +: 7] = seg_left_reg;
                rdata_next[ssd_pkg::RB_SEG_R_POS +: 7] = seg_right_reg;
            end
            default: rdata_next = ssd_pkg::RDATA_IDLE;
        endcase
    end

    // read data stands one cycle only, zero otherwise
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rdata_reg <= ssd_pkg::RDATA_IDLE;
        end else if (i_rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= ssd_pkg::RDATA_IDLE;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_out_word = out_reg;
    assign o_seg_left = seg_left_reg;
    assign o_seg_right = seg_right_reg;
    assign o_running = run_now;

    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    round_wrap_a: assert property (
        (run_now && ctrl_run_reg && step_reg == ssd_pkg::STEP_LAST)
        |=> (run_now && step_reg == ssd_pkg::STEP_FIRST))
        else $error("round did not wrap to step zero");

    step_adv_a: assert property (
        (run_now && ctrl_run_reg && step_reg != ssd_pkg::STEP_LAST)
        |=> (step_reg == $past(step_reg) + 4'h1))
        else $error("step did not advance by one");

    flag_once_a: assert property (
        flag_comb |=> !flag_comb [*8])
        else $error("round flag repeated too soon");

    flag_pos8_a: assert property (
        (flag_comb && mode_reg[ssd_pkg::MODE_EIGHT])
        |=> o_out_word[ssd_pkg::POS8_FLAG])
        else $error("8-digit round flag missing");

    flag_pos4_a: assert property (
        (flag_comb && !mode_reg[ssd_pkg::MODE_EIGHT])
        |=> (o_out_word[ssd_pkg::POS4_FLAG] &&
             o_out_word[15:9] == 7'h00))
        else $error("4-digit layout wrong on flag step");

    snap_load_a: assert property (
        round_start |=> (snap_reg == $past(src_reg)))
        else $error("source not resampled at round start");

    start_zero_a: assert property (
        (!run_now && ctrl_run_reg)
        |=> (run_now && step_reg == ssd_pkg::STEP_FIRST))
        else $error("start not at strobe zero");

    strobe_hold_a: assert property (
        (run_now && ctrl_run_reg && phase == ssd_pkg::PHASE_STROBE)
        |-> (left_raw == $past(left_raw)) ##1
            (left_raw == $past(left_raw)))
        else $error("data moved around strobe");

    strobe_hot_a: assert property (
        (run_now && phase == ssd_pkg::PHASE_STROBE)
        |-> $onehot(strobe_raw))
        else $error("strobe not one-hot");

    latch_pol_a: assert property (
        (run_now && eight && phase != ssd_pkg::PHASE_STROBE)
        |=> (o_out_word[ssd_pkg::POS8_STRB +: 4] ==
             {4{$past(latch_inv)}}))
        else $error("idle strobe level wrong");

    // the fourth strobe shows one cycle after its step; a stop may
    // cut the round short, so look only at the strobe step itself
    last_digit_a: assert property (
        (run_now && eight && dig_idx == 2'h3 &&
         phase == ssd_pkg::PHASE_STROBE)
        |=> (o_out_word[ssd_pkg::POS8_STRB + 3] != $past(latch_inv)))
        else $error("eighth digit strobe missing");

    round8_c: cover property (flag_comb && eight);
    stop_mid_c: cover property (
        run_now && !ctrl_run_reg && step_reg != ssd_pkg::STEP_LAST);
    restart_c: cover property (
        !run_now && ctrl_run_reg && round_reg != ssd_pkg::ROUND_RST);
endmodule

//--- test/ssd_disp_model.sv
`timescale 1ns/1ps
module ssd_disp_model (
    input wire logic i_clk, // scan clock
    input wire logic [15:0] i_word, // driver output word
    input wire logic [2:0] i_mode, // mode code the display is wired for
    output logic [31:0] o_shown // latched digits, true polarity
);
    logic eight;
    logic [3:0] strb;
    logic [7:0] dat;
    logic [31:0] latched = 32'h0000_0000;

    always_comb begin
        eight = i_mode[2];
        strb = eight ? i_word[11:8] : i_word[7:4];
        dat = i_word[7:0];
        if (i_mode[0]) begin
            strb = ~strb;
        end
        if (i_mode[1]) begin
            dat = ~dat;
        end
    end

    // edge-clocked latch per digit
    // a latch only holds what stood on the lines while its strobe was on
    always @(posedge i_clk) begin
        for (int d = 0; d < 4; d++) begin
            if (strb[d]) begin
                latched[4*d +: 4] <= eight ? dat[7:4] : dat[3:0];
                if (eight) begin
                    latched[16+4*d +: 4] <= dat[3:0];
                end
            end
        end
    end

    assign o_shown = latched;
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic [15:0] o_out_word;
    logic [6:0] o_seg_left;
    logic [6:0] o_seg_right;
    logic o_running;
    logic [2:0] disp_mode = 3'h0;
    logic [31:0] shown;
    logic [31:0] rv;
    int n_fail = 0;
    int total_checks = 0;

    always #12.5 i_clk = ~i_clk;

    ssd_mux_driver i_ssd_mux_driver (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_out_word(o_out_word),
        .o_seg_left(o_seg_left), .o_seg_right(o_seg_right),
        .o_running(o_running));
    ssd_disp_model i_ssd_disp_model (.i_clk(i_clk), .i_word(o_out_word),
        .i_mode(disp_mode), .o_shown(shown));

    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        d = o_rdata;
    endtask

    function automatic logic [15:0] exp_word(logic [2:0] m, logic [31:0] s,
                                             int k);
        int d;
        logic [3:0] st;
        logic [3:0] l;
        logic [3:0] r;
        d = k / 3;
        l = s[16+4*d +: 4];
        r = s[4*d +: 4];
        st = (k % 3 == 1) ? (4'h1 << d) : 4'h0;
        if (m[0]) st = ~st;
        if (m[1]) begin
            l = ~l;
            r = ~r;
        end
        if (m[2]) return {3'h0, k == 11, st, r, l};
        return {7'h0, k == 11, st, r};
    endfunction

    function automatic logic [6:0] seg_pat(logic [3:0] v, logic inv);
        logic [6:0] p;
        case (v)
            4'h0: p = 7'h3F;
            4'h1: p = 7'h06;
            4'h2: p = 7'h5B;
            4'h3: p = 7'h4F;
            4'h4: p = 7'h66;
            4'h5: p = 7'h6D;
            4'h6: p = 7'h7D;
            4'h7: p = 7'h07;
            4'h8: p = 7'h7F;
            4'h9: p = 7'h6F;
            default: p = 7'h00;
        endcase
        return inv ? ~p : p;
    endfunction

    // two rounds; source rewritten mid-round one shows only in round two
    task automatic run_rounds(input logic [2:0] m, input logic [31:0] sa,
                              input logic [31:0] sb);
        logic [31:0] s;
        logic [31:0] mask;
        int d;
        disp_mode <= m;
        // stop first: a run already going would not restart at step zero
        wr(ssd_pkg::REG_CTRL, {28'h0000_000, 1'b0, m});
        wr(ssd_pkg::REG_SRC, sa);
        wr(ssd_pkg::REG_CTRL, {28'h0000_000, 1'b1, m});
        repeat (2) @(posedge i_clk);
        for (int k = 0; k < 24; k++) begin
            s = (k < 12) ? sa : sb;
            d = (k % 12) / 3;
            @(negedge i_clk);
            chk({16'h0000, o_out_word}, {16'h0000, exp_word(m, s, k % 12)});
            if (k % 3 == 1) begin
                chk({25'h0, o_seg_left}, {25'h0, seg_pat(m[2] ?
                    s[16+4*d +: 4] : s[4*d +: 4], m[1])});
                if (m[2]) begin
                    chk({25'h0, o_seg_right},
                        {25'h0, seg_pat(s[4*d +: 4], m[1])});
                end else begin
                    chk({25'h0, o_seg_right}, 32'h0000_0000);
                end
            end
            @(posedge i_clk);
            if (k == 4) begin
                i_addr <= ssd_pkg::REG_SRC;
                i_wdata <= sb;
                i_wr <= 1'b1;
            end else begin
                i_wr <= 1'b0;
            end
        end
        // display got every digit of the chosen count
        mask = m[2] ? 32'hFFFF_FFFF : 32'h0000_FFFF;
        chk(shown & mask, sb & mask);
    endtask

    // stop mid-round, then restart must begin at strobe zero
    task automatic stop_restart();
        wr(ssd_pkg::REG_CTRL, 32'h0000_000D);
        rd(ssd_pkg::REG_CTRL, rv);
        chk(rv, 32'h0000_000D);
        rd(ssd_pkg::REG_STATUS, rv);
        chk({31'h0, rv[0]}, 32'h0000_0001);
        repeat (5) @(posedge i_clk);
        wr(ssd_pkg::REG_CTRL, 32'h0000_0005);
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk({31'h0, o_running}, 32'h0000_0000);
        run_rounds(3'h5, 32'h8034_1205, 32'h0012_5480);
    endtask

    task automatic reset_mid_run();
        wr(ssd_pkg::REG_CTRL, 32'h0000_000E);
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk({16'h0000, o_out_word}, 32'h0000_0000);
        chk({31'h0, o_running}, 32'h0000_0000);
        @(posedge i_clk);
        i_nrst <= 1'b1;
        rd(ssd_pkg::REG_CTRL, rv);
        chk(rv, 32'h0000_0000);
        run_rounds(3'h6, 32'h2108_5340, 32'hF3A1_0679);
    endtask

    // working state cleared before first use, then register map
    task automatic reset_regs();
        repeat (10) @(posedge i_clk);
        @(negedge i_clk);
        chk({16'h0000, o_out_word}, 32'h0000_0000);
        chk({18'h0, o_seg_left, o_seg_right}, 32'h0000_0000);
        @(posedge i_clk);
        i_nrst <= 1'b1;
        rd(ssd_pkg::REG_STATUS, rv);
        chk(rv, 32'h0000_0000);
        wr(8'h10, 32'h0000_000F);
        rd(8'h10, rv);
        chk(rv, 32'h0000_0000);
        rd(ssd_pkg::REG_CTRL, rv);
        chk(rv, 32'h0000_0000);
    endtask

    initial begin
        reset_regs();
        // every mode code 0 to 7
        for (int m = 0; m < 8; m++) begin
            run_rounds(m[2:0], 32'h1234_5080, 32'h35A8_04F1);
        end
        stop_restart();
        reset_mid_run();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        n_fail++;
        summarize();
    end
endmodule
